// ==== core/dpram_port_host.sv ====
// Controller driving one port of the dual-port memory through its pins
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Held host keeps operation and address pending
// - Delay slave write by arbitration time
// - Keep write strobe after hold release
// - Only master arbitrates, feeds slave holds
module dpram_port_host
	import dpram_host_pkg::*;
(
	input  wire logic                        clk_i,        // 10 MHz clock
	input  wire logic                        arst_n_i,     // Async reset, active low
	input  wire dpram_host_pkg::req_t        req_i,        // Request contents
	input  wire logic                        req_valid_i,  // Request offered
	output logic                             req_ready_o,  // Request taken
	output logic [dpram_host_pkg::DATA_W-1:0] rdata_o,     // Read result
	output logic                             done_o,       // Access finished pulse
	output logic                             mailbox_o,    // Mailbox flag seen active
	output dpram_host_pkg::port_pins_t       pins_o,       // Pins toward memory port
	input  wire logic [dpram_host_pkg::DATA_W-1:0] data_i, // Data pins read back
	input  wire logic                        hold_flag_n_i, // Port hold flag pin
	input  wire logic                        mailbox_flag_n_i // Port mailbox flag pin
);
	import dpram_host_pkg::*;

	state_t cur;
	state_t next_cur;

	// Idle pins: deselected, outputs off, read direction
	function automatic port_pins_t idle_pins();
		port_pins_t p;
		p = '0;
		p.select_n = 1'b1;
		p.out_en_n = 1'b1;
		p.rw_n     = 1'b1;
		return p;
	endfunction

	// Flag pin inputs come from the memory's clock-free domain, so two stages first
	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.hold_s1 = hold_flag_n_i;
		next_cur.hold_s2 = cur.hold_s1;
		next_cur.flag_s1 = mailbox_flag_n_i;
		next_cur.flag_s2 = cur.flag_s1;
		case (cur.phase)
			ST_IDLE: begin
				next_cur.pins = idle_pins();
				if (req_valid_i) begin
					next_cur.req = req_i;
					next_cur.pins.addr = req_i.addr; // Address first, then select
					next_cur.pins.rw_n = 1'b1;
					next_cur.phase = ST_SETUP;
					next_cur.count = ARB_CNT;
				end
			end
			ST_SETUP: begin
				// Select and strobe after address has settled for arbitration
				if (cur.count > 4'h1) begin
					next_cur.count = cur.count - 4'h1;
				end else begin
					next_cur.pins.select_n = 1'b0;
					next_cur.pins.rw_n     = ~cur.req.write;
					next_cur.pins.out_en_n = cur.req.write;
					next_cur.pins.data_out = cur.req.data;
					next_cur.pins.data_oe  = cur.req.write;
					// First strobe outlasts the synchroniser, or a hold would be missed
					next_cur.count = 4'(STROBE_CNT + SYNC_CNT);
					next_cur.phase = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (!cur.hold_s2) begin
					// Held: keep operation and address pending until released
					next_cur.phase = ST_HELD;
				end else if (cur.count > 4'h1) begin
					next_cur.count = cur.count - 4'h1;
				end else begin
					if (!cur.req.write) begin
						next_cur.rdata = data_i;
					end
					next_cur.count = HOLD_CNT;
					next_cur.phase = ST_HOLD;
				end
			end
			ST_HELD: begin
				// Strobe still active; restart the full strobe once released
				if (cur.hold_s2) begin
					next_cur.count = STROBE_CNT;
					next_cur.phase = ST_STROBE;
				end
			end
			ST_HOLD: begin
				next_cur.pins = idle_pins();
				next_cur.pins.addr = cur.pins.addr;
				next_cur.done = 1'b1;
				next_cur.phase = ST_IDLE;
			end
			default: next_cur.phase = ST_IDLE;
		endcase
	end

	// State register; reset deselects the port
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cur <= '{phase: ST_IDLE, count: 4'h0, req: '0,
				pins: '{select_n: 1'b1, out_en_n: 1'b1, rw_n: 1'b1,
				addr: '0, data_out: '0, data_oe: 1'b0},
				rdata: '0, done: 1'b0, hold_s1: 1'b1, hold_s2: 1'b1,
				flag_s1: 1'b1, flag_s2: 1'b1};
		end else begin
			cur <= next_cur;
		end
	end

	assign req_ready_o = (cur.phase == ST_IDLE);
	assign pins_o      = cur.pins;
	assign rdata_o     = cur.rdata;
	assign done_o      = cur.done;
	assign mailbox_o   = ~cur.flag_s2;

	// Assertions
	sequence strobe_start;
		cur.phase == ST_SETUP && next_cur.phase == ST_STROBE;
	endsequence

	deselect_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cur.phase == ST_IDLE |-> cur.pins.select_n && !cur.pins.data_oe)
		else $error("idle port not deselected");
	read_no_drive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!cur.pins.rw_n || !cur.pins.data_oe)
		else $error("host drives data during read");
	held_pending_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cur.phase == ST_HELD |=> cur.pins.select_n == 1'b0 && $stable(cur.pins.addr))
		else $error("held access not kept pending");
	write_delay_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cur.phase == ST_IDLE && req_valid_i |=> cur.pins.select_n ##1 1'b1)
		else $error("strobe not delayed after address");
	strobe_enter_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		strobe_start |=> cur.pins.rw_n == ~cur.req.write && !cur.pins.select_n)
		else $error("strobe direction wrong");
	release_restart_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cur.phase == ST_HELD && cur.hold_s2 |=> cur.phase == ST_STROBE
			&& cur.count == STROBE_CNT)
		else $error("write not extended after release");
	read_oe_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		strobe_start |=> cur.pins.out_en_n == cur.req.write)
		else $error("output enable wrong for access");
	done_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		cur.phase == ST_HOLD |=> done_o && cur.pins.select_n ##1 !done_o)
		else $error("done pulse wrong");
endmodule

`default_nettype wire

// ==== core/dpram_host_pkg.sv ====
// Package for the dual-port memory port controller: pins, timing, mailbox map
package dpram_host_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam logic [9:0] LEFT_MAILBOX  = 10'h3fe;
	localparam logic [9:0] RIGHT_MAILBOX = 10'h3ff;
	// Clock period and pin timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int ARB_TIME_NS   = 5;   // Arbitration resolution window
	localparam int WRITE_HOLD_NS = 20;  // Write hold after hold flag releases
	localparam int STROBE_NS     = 200; // Select/strobe active width
	localparam int ARB_CYCLES    = (ARB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYCLES   = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] ARB_CNT    = 4'(ARB_CYCLES);
	localparam logic [3:0] HOLD_CNT   = 4'(HOLD_CYCLES);
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYCLES);
	// Cycles the hold flag needs to cross its two synchroniser stages
	localparam logic [3:0] SYNC_CNT   = 4'h2;

	// One request from the user side
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} req_t;

	// Pins toward one port of the memory
	typedef struct packed {
		logic              select_n;
		logic              out_en_n;
		logic              rw_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} port_pins_t;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HELD, ST_HOLD} phase_t;

	typedef struct packed {
		phase_t            phase;
		logic [3:0]        count;
		req_t              req;
		port_pins_t        pins;
		logic [DATA_W-1:0] rdata;
		logic              done;
		logic              hold_s1;
		logic              hold_s2;
		logic              flag_s1;
		logic              flag_s2;
	} state_t;
endpackage

// ==== test/dpram_device_model.sv ====
// Behavioural model of the memory port facing the host, right port driven by bench
`timescale 1ns/1ps
`default_nettype none
module dpram_device_model
	import dpram_host_pkg::*;
(
	input  wire dpram_host_pkg::port_pins_t        pins_i,    // Left port pins
	output var  logic [dpram_host_pkg::DATA_W-1:0] data_o,    // Left data pins
	output var  logic                              hold_n_o,  // Left hold flag
	output var  logic                              flag_n_o,  // Left mailbox flag
	input  wire logic                              r_sel_n_i, // Right select
	input  wire logic                              r_we_n_i,  // Right write strobe
	input  wire logic [dpram_host_pkg::ADDR_W-1:0] r_addr_i,  // Right address
	input  wire logic [dpram_host_pkg::DATA_W-1:0] r_data_i   // Right data
);
	import dpram_host_pkg::*;
	logic [DATA_W-1:0] mem [0:1023];
	logic [DATA_W-1:0] last;
	port_pins_t        cur;
	logic              ch;
	initial flag_n_o = 1'b1;
	// Right is always selected first in the bench, so it wins every tie
	assign hold_n_o = !(!pins_i.select_n && !r_sel_n_i && pins_i.addr == r_addr_i);
	// A released bus shows the inverse of the last word so stale data never matches
	assign data_o = (!pins_i.select_n && pins_i.rw_n && !pins_i.out_en_n) ?
		mem[pins_i.addr] : ~last;
	// Control and data pins move on the deselect edge, so remember them while selected
	always @(pins_i, hold_n_o) begin
		if (!pins_i.select_n) begin
			cur = pins_i;
			ch = hold_n_o;
		end
	end
	always @(posedge pins_i.select_n) begin
		if (!cur.rw_n && ch) mem[cur.addr] = cur.data_out;
		if (cur.rw_n && !cur.out_en_n && ch && cur.addr == 10'h3fe) flag_n_o = 1'b1;
		last = mem[cur.addr];
	end
	always @(negedge r_we_n_i) begin
		mem[r_addr_i] = r_data_i;
		if (r_addr_i == 10'h3fe) flag_n_o = 1'b0;
	end
endmodule
`default_nettype wire

// ==== test/dpram_port_host_test.sv ====
// Self-checking bench for the memory port controller
`timescale 1ns/1ps
`default_nettype none
module dpram_port_host_test;
	import dpram_host_pkg::*;
	logic              clk, arst_n, valid, ready, done, mbox, hold_n, flag_n, r_sel_n, r_we_n;
	logic [ADDR_W-1:0] r_addr, a;
	logic [DATA_W-1:0] r_data, rdata, din, d;
	req_t              req;
	port_pins_t        pins;
	int                error_cnt, checked, t0;
	dpram_port_host uut (.clk_i(clk), .arst_n_i(arst_n), .req_i(req), .req_valid_i(valid),
		.req_ready_o(ready), .rdata_o(rdata), .done_o(done), .mailbox_o(mbox), .pins_o(pins),
		.data_i(din), .hold_flag_n_i(hold_n), .mailbox_flag_n_i(flag_n));
	dpram_device_model dev (.pins_i(pins), .data_o(din), .hold_n_o(hold_n), .flag_n_o(flag_n),
		.r_sel_n_i(r_sel_n), .r_we_n_i(r_we_n), .r_addr_i(r_addr), .r_data_i(r_data));
	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One request, then wait for completion under a bound
	task automatic access(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd);
		int n;
		n = 0;
		req <= '{write: w, addr: ad, data: dd};
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
		do @(posedge clk); while (!done && ++n < 60);
		chk(8'(done), 8'h1);
	endtask
	task automatic summarize();
		$display("checked %0d, error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cut a hang short well past the expected few hundred cycles
	initial begin
		#(3000 * 100);
		error_cnt++;
		summarize();
	end
	initial begin
		arst_n = 1'b0; valid = 1'b0; req = '0; r_sel_n = 1'b1; r_we_n = 1'b1;
		r_addr = '0; r_data = '0; error_cnt = 0; checked = 0;
		void'($urandom(32'h160f));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk(8'(mbox), 8'h0);
		// Boundary addresses first, then random ones
		for (int i = 0; i < 10; i++) begin
			a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3fd : 10'($urandom % 1022);
			d = 8'($urandom);
			access(1'b1, a, d);
			access(1'b0, a, 8'h00);
			chk(rdata, d);
		end
		$display("read write test ended");
		r_addr <= 10'h3fe; r_data <= 8'h5a;
		@(posedge clk);
		r_sel_n <= 1'b0; r_we_n <= 1'b0;
		@(posedge clk);
		r_sel_n <= 1'b1; r_we_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(8'(mbox), 8'h1);
		access(1'b0, 10'h3fe, 8'h00);
		chk(rdata, 8'h5a);
		repeat (4) @(posedge clk);
		chk(8'(mbox), 8'h0);
		$display("mailbox test ended");
		// Right port holds the location, the host write must wait for it
		access(1'b1, 10'h155, 8'h3c);
		r_addr <= 10'h155; r_sel_n <= 1'b0;
		@(posedge clk);
		t0 = $time;
		fork
			begin
				repeat (8) @(posedge clk);
				chk(8'(pins.select_n), 8'h0);
				chk(dev.mem[10'h155], 8'h3c);
				repeat (4) @(posedge clk);
				r_sel_n <= 1'b1;
			end
			access(1'b1, 10'h155, 8'hc3);
		join
		chk(8'(($time - t0) >= 1200), 8'h1);
		access(1'b0, 10'h155, 8'h00);
		chk(rdata, 8'hc3);
		$display("contention test ended");
		summarize();
	end
endmodule
`default_nettype wire
